// ===== rtl/isabcu_top.sv
// isa bus cycle unit: slave i/o and memory cycles, current master sequencing
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module isabcu_top
	import isabcu_pkg::*;
#(
	parameter logic [15:0] IO_BASE = 16'h0300, // i/o window base, low 5 bits unused
	parameter logic [23:0] BOOT_BASE = 24'h0C8000 // boot window, 16 Kbyte aligned
)
(
	input wire logic clk, // 250 MHz clock
	input wire logic nrst, // synchronous reset, active low
	input wire isabcu_axil_req_type axi_i, // register bus requests
	output var isabcu_axil_rsp_type axi_o, // register bus answers
	input wire isabcu_isa_in_type isa_i, // isa pin levels
	output var isabcu_isa_out_type isa_o, // isa pin drives and enables
	input wire logic private_data_bus_gnt, // private bus granted
	input wire logic [7:0] private_data_lines, // prom data
	output var isabcu_priv_out_type prv_o, // private bus request, address, selects
	output var isabcu_core_out_type core_o, // internal register access and reset
	input wire logic [15:0] core_rdata // core data, sampled in the cycle rd is high
);
	isabcu_main_type r_ff, nxt_r;
	logic soft_rst;
	logic tmr_load;
	logic [7:0] tmr_count;
	logic tmr_done;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic io_hit;
	logic prom_hit;
	logic rst_hit;
	logic reg_hit;
	logic boot_hit;
	logic dack_ok;
	logic busy;

	isabcu_timer #(.W(8)) u_timer (
		.clk(clk),
		.nrst(nrst),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);

	isabcu_axil_slave u_slave (
		.clk(clk),
		.nrst(nrst),
		.req(axi_i),
		.rsp(axi_o),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(reg_mapped(wr_addr)),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(reg_mapped(rd_addr))
	);

	// address decodes; aen only matters for i/o space
	assign io_hit = !isa_i.aen && isa_i.sa[15:5] == IO_BASE[15:5];
	assign prom_hit = io_hit && !isa_i.sa[4] && !isa_i.ior_n;
	assign rst_hit = io_hit && isa_i.sa[4:1] == IO_RESET_PORT[4:1] && !isa_i.ior_n;
	// writes to the reset port never match anything and are left alone
	assign reg_hit = io_hit && isa_i.sa[4] && isa_i.sa[4:1] != IO_RESET_PORT[4:1]
		&& !isa_i.sa[3] && (!isa_i.ior_n || !isa_i.iow_n);
	// refresh masks the memory read and any false acknowledge
	assign boot_hit = r_ff.ctrl[CTRL_BUS_MASTER_BIT]
		&& isa_i.sa[23:14] == BOOT_BASE[23:14]
		&& isa_i.ref_n && !isa_i.smemr_n;
	assign dack_ok = !isa_i.dack_n && isa_i.ref_n;
	assign soft_rst = r_ff.st == S_IDLE && rst_hit;
	assign busy = |(r_ff.st & MASTER_STATES);

	// register bus read view
	always_comb
	begin
		case (rd_addr)
			A_CTRL: rd_data = r_ff.ctrl;
			A_MADDR: rd_data = {8'h00, r_ff.maddr};
			A_MDATA: rd_data = {16'h0000, r_ff.mwdata};
			A_MCMD: rd_data = {r_ff.mrdata, 12'h000, r_ff.io16_seen, r_ff.pend,
				busy, r_ff.mwrite};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// first master address phase: address, word enable, commands inactive
	function automatic isabcu_isa_out_type start_cycle(input isabcu_main_type s);
		isabcu_isa_out_type o;
		o = s.isa;
		o.sa = s.maddr;
		o.sbhe_n = 1'b0;
		o.sa_oe = 1'b1;
		o.cmd_oe = 1'b1;
		o.memr_n = 1'b1;
		o.memw_n = 1'b1;
		o.sd = s.mwdata;
		o.sd_oe_lo = s.mwrite;
		o.sd_oe_hi = s.mwrite;
		return o;
	endfunction

	// main sequencer
	always_comb
	begin
		nxt_r = r_ff;
		tmr_load = 1'b0;
		tmr_count = 8'h00;
		nxt_r.core.wr = 1'b0;
		nxt_r.core.rd = 1'b0;
		nxt_r.core.reset = 1'b0;
		// pin is only an input while we leave it alone
		if (!r_ff.isa.iocs16_oe && isa_i.iocs16_n)
			nxt_r.io16_seen = 1'b1;
		case (r_ff.st)
			S_IDLE:
			begin
				if (prom_hit)
				begin
					nxt_r.isa.iochrdy_oe = 1'b1;
					nxt_r.prv.private_data_bus_req = 1'b1;
					nxt_r.prv.addr = {10'h000, isa_i.sa[3:0]};
					nxt_r.st = S_PROM_ARB;
				end
				else if (reg_hit)
				begin
					nxt_r.isa.iochrdy_oe = 1'b1;
					nxt_r.isa.iocs16_oe = r_ff.io16_seen;
					nxt_r.ack = 1'b0;
					nxt_r.rd_wait = 1'b0;
					nxt_r.st = S_REG;
				end
				else if (boot_hit)
				begin
					nxt_r.isa.iochrdy_oe = 1'b1;
					nxt_r.prv.private_data_bus_req = 1'b1;
					nxt_r.prv.addr = isa_i.sa[13:0];
					nxt_r.st = S_BOOT_ARB;
				end
				else if (r_ff.pend && r_ff.ctrl[CTRL_BUS_MASTER_BIT])
				begin
					nxt_r.isa.drq = 1'b1;
					nxt_r.st = S_M_REQ;
				end
			end
			S_PROM_ARB:
			begin
				if (private_data_bus_gnt)
				begin
					nxt_r.prv.station_prom_select_n = 1'b0;
					nxt_r.st = S_PROM_DRV;
				end
			end
			S_PROM_DRV:
			begin
				// low lane only, iocs16 left alone
				nxt_r.isa.sd[7:0] = private_data_lines;
				nxt_r.isa.sd_oe_lo = 1'b1;
				nxt_r.isa.iochrdy_oe = 1'b0;
				if (isa_i.ior_n)
				begin
					nxt_r.isa.sd_oe_lo = 1'b0;
					nxt_r.prv.station_prom_select_n = 1'b1;
					nxt_r.prv.private_data_bus_req = 1'b0;
					nxt_r.st = S_IDLE;
				end
			end
			S_REG:
			begin
				if (isa_i.ior_n && isa_i.iow_n)
				begin
					// command gone: end of cycle
					nxt_r.isa.iochrdy_oe = 1'b0;
					nxt_r.isa.iocs16_oe = 1'b0;
					nxt_r.isa.sd_oe_lo = 1'b0;
					nxt_r.isa.sd_oe_hi = 1'b0;
					nxt_r.st = S_IDLE;
				end
				else if (!r_ff.ack && !isa_i.iow_n)
				begin
					nxt_r.ack = 1'b1;
					nxt_r.isa.iochrdy_oe = 1'b0;
					if (!r_ff.io16_seen && !isa_i.sa[0])
						nxt_r.hold_byte = isa_i.sd[7:0];
					else
					begin
						// odd byte arrives on the low lane in 8-bit mode
						logic [15:0] w;
						w = r_ff.io16_seen ? isa_i.sd : {isa_i.sd[7:0], r_ff.hold_byte};
						if (isa_i.sa[4:1] == IO_REGISTER_INDEX_PORT[4:1])
							nxt_r.register_index_port = w;
						else
						begin
							nxt_r.core.wr = 1'b1;
							nxt_r.core.bus_config_sel =
								isa_i.sa[4:1] == IO_CONFIG_DATA_PORT[4:1];
							nxt_r.core.idx = r_ff.register_index_port;
							nxt_r.core.wdata = w;
						end
					end
				end
				else if (!r_ff.ack && !isa_i.ior_n)
				begin
					if (isa_i.sa[4:1] != IO_REGISTER_INDEX_PORT[4:1] && !r_ff.rd_wait)
					begin
						nxt_r.core.rd = 1'b1;
						nxt_r.core.bus_config_sel =
							isa_i.sa[4:1] == IO_CONFIG_DATA_PORT[4:1];
						nxt_r.core.idx = r_ff.register_index_port;
						nxt_r.rd_wait = 1'b1;
					end
					else
					begin
						logic [15:0] w;
						w = r_ff.rd_wait ? core_rdata : r_ff.register_index_port;
						nxt_r.ack = 1'b1;
						nxt_r.isa.iochrdy_oe = 1'b0;
						nxt_r.isa.sd_oe_lo = 1'b1;
						if (r_ff.io16_seen)
						begin
							nxt_r.isa.sd = w;
							nxt_r.isa.sd_oe_hi = 1'b1;
						end
						else
							nxt_r.isa.sd[7:0] = isa_i.sa[0] ? w[15:8] : w[7:0];
					end
				end
			end
			S_WAIT_END:
			begin
				// the reset read must finish before a new cycle is decoded
				if (isa_i.ior_n)
					nxt_r.st = S_IDLE;
			end
			S_BOOT_ARB:
			begin
				if (private_data_bus_gnt)
				begin
					nxt_r.prv.boot_rom_select_n = 1'b0;
					tmr_load = 1'b1;
					tmr_count = CYC_BOOT_SELECT;
					nxt_r.st = S_BOOT_SEL;
				end
			end
			S_BOOT_SEL:
			begin
				if (tmr_done)
				begin
					nxt_r.prv.boot_rom_select_n = 1'b1;
					nxt_r.isa.sd[7:0] = private_data_lines;
					nxt_r.isa.sd_oe_lo = 1'b1;
					nxt_r.isa.iochrdy_oe = 1'b0;
					nxt_r.st = S_BOOT_DRV;
				end
			end
			S_BOOT_DRV:
			begin
				if (isa_i.smemr_n)
				begin
					nxt_r.isa.sd_oe_lo = 1'b0;
					nxt_r.prv.private_data_bus_req = 1'b0;
					nxt_r.st = S_IDLE;
				end
			end
			S_M_REQ:
			begin
				if (dack_ok)
				begin
					nxt_r.isa.master_n = 1'b0;
					tmr_load = 1'b1;
					tmr_count = CYC_SETTLE;
					nxt_r.st = S_M_SETTLE;
				end
			end
			S_M_SETTLE:
			begin
				if (tmr_done)
				begin
					nxt_r.isa = start_cycle(r_ff);
					nxt_r.pend = 1'b0;
					tmr_load = 1'b1;
					tmr_count = CYC_SETUP;
					nxt_r.st = S_M_SETUP;
				end
			end
			S_M_SETUP:
			begin
				if (tmr_done)
				begin
					tmr_load = 1'b1;
					if (r_ff.mwrite)
					begin
						nxt_r.isa.memw_n = 1'b0;
						tmr_count = bclk_cycles(r_ff.ctrl[CTRL_WRITE_ACTIVE_LSB +: 4]);
					end
					else
					begin
						nxt_r.isa.memr_n = 1'b0;
						tmr_count = bclk_cycles(r_ff.ctrl[CTRL_READ_ACTIVE_LSB +: 4]);
					end
					nxt_r.st = S_M_STROBE;
				end
			end
			S_M_STROBE:
			begin
				// size indications are ignored, only iochrdy can stretch
				if (tmr_done && isa_i.iochrdy)
				begin
					nxt_r.isa.memr_n = 1'b1;
					nxt_r.isa.memw_n = 1'b1;
					tmr_load = 1'b1;
					if (r_ff.mwrite)
					begin
						tmr_count = CYC_WRITE_HOLD;
						nxt_r.st = S_M_HOLD;
					end
					else
					begin
						nxt_r.mrdata = isa_i.sd;
						tmr_count = r_ff.ctrl[CTRL_RECOV_FAST_BIT] ?
							CYC_RECOV_FAST : CYC_RECOV_SLOW;
						nxt_r.st = S_M_RECOV;
					end
				end
			end
			S_M_HOLD:
			begin
				if (tmr_done)
				begin
					nxt_r.isa.sd_oe_lo = 1'b0;
					nxt_r.isa.sd_oe_hi = 1'b0;
					tmr_load = 1'b1;
					tmr_count = r_ff.ctrl[CTRL_RECOV_FAST_BIT] ?
						CYC_RECOV_FAST : CYC_RECOV_SLOW;
					nxt_r.st = S_M_RECOV;
				end
			end
			S_M_RECOV:
			begin
				// queued command keeps the bus, otherwise start the release
				if (tmr_done && r_ff.pend && r_ff.ctrl[CTRL_BUS_MASTER_BIT])
				begin
					nxt_r.isa = start_cycle(r_ff);
					nxt_r.pend = 1'b0;
					tmr_load = 1'b1;
					tmr_count = CYC_SETUP;
					nxt_r.st = S_M_SETUP;
				end
				else if (tmr_done)
				begin
					// commands have been inactive for well over 50 ns by now
					nxt_r.isa.cmd_oe = 1'b0;
					nxt_r.isa.sa_oe = 1'b0;
					nxt_r.isa.sd_oe_lo = 1'b0;
					nxt_r.isa.sd_oe_hi = 1'b0;
					nxt_r.isa.drq = 1'b0;
					tmr_load = 1'b1;
					tmr_count = CYC_RELEASE;
					nxt_r.st = S_M_REL;
				end
			end
			S_M_REL:
			begin
				if (tmr_done)
				begin
					nxt_r.isa.master_n = 1'b1;
					nxt_r.st = S_IDLE;
				end
			end
			default:
				nxt_r = MAIN_RST;
		endcase
		// software writes last, so a new start outlives the clear above
		if (wr_stb)
		begin
			case (wr_addr)
				A_CTRL: nxt_r.ctrl = apply_strb(r_ff.ctrl, wr_data, wr_strb);
				A_MADDR: nxt_r.maddr = 24'(apply_strb({8'h00, r_ff.maddr}, wr_data, wr_strb));
				A_MDATA: nxt_r.mwdata = 16'(apply_strb({16'h0000, r_ff.mwdata}, wr_data,
					wr_strb));
				A_MCMD:
				begin
					if (wr_strb[0])
					begin
						nxt_r.mwrite = wr_data[0];
						nxt_r.pend = 1'b1;
					end
				end
				default: nxt_r.pend = nxt_r.pend;
			endcase
		end
	end

	// state register; a reset-port read reloads it like the pin, but the timer and register bus slave are not reset
	always_ff @(posedge clk)
	begin
		if (!nrst)
			r_ff <= MAIN_RST;
		else if (soft_rst)
			r_ff <= MAIN_SOFT_RST;
		else
			r_ff <= nxt_r;
	end

	assign isa_o = r_ff.isa;
	assign prv_o = r_ff.prv;
	assign core_o = r_ff.core;
endmodule
`default_nettype wire

// ===== rtl/isabcu_pkg.sv
// constants, carriers and helpers of the isa bus cycle unit
// Overview of operation
// - while refresh is active, ignore system memory read and the dma acknowledge
// - station prom: 8-bit i/o reads only; hold iochrdy low, request private bus
// - on grant: select prom, release iochrdy, drive low byte, no iocs16, until ior ends
// - if iocs16 never seen high since reset, register cycles are 8-bit only
// - 8-bit reads drive only the low byte, odd byte shifted down
// - 8-bit writes: even byte held, odd byte merged into one 16-bit write
// - register cycle: iochrdy low, iocs16 low if 16-bit, release when data ready
// - reset port read resets like the pin; writes ignored; no iocs16
// - config registers go through index and config data ports like other registers
// - bus master mode: boot window up to 16 Kbyte, 8-bit memory cycles only
// - boot read: iochrdy low, fetch byte, drive low lines, hold until read ends
// - boot rom select lasts three 20 MHz clocks, 150 ns
// - master only in bus master mode; raise drq, assert master after dack
// - wait 150 ns after master before driving address, command or data
// - target assumed 16-bit, one wait state; size indications ignored
// - release: commands inactive, 50 ns later float and drop drq, 50 ns later master
// - master read: address one clock (50 ns) before memory read
// - memory read active default 5 clocks, tunable; end after counter and iochrdy high
// - master write: data one clock early, strobe 5 clocks tunable, stall on iochrdy
// - write data held one clock (50 ns) after write strobe ends
// - recovery between cycles 100 ns with bit 4 set, 200 ns when clear
package isabcu_pkg;
	localparam int CLK_NS = 4;
	localparam int BUS_CLK_NS = 50;
	localparam int SETTLE_NS = 150;
	localparam int BOOT_SELECT_NS = 150;
	localparam int SETUP_NS = 50;
	localparam int WRITE_HOLD_NS = 50;
	localparam int RELEASE_NS = 50;
	localparam int RECOV_FAST_NS = 100;
	localparam int RECOV_SLOW_NS = 200;
	// least times, rounded up to whole cycles
	function automatic logic [7:0] ns_cycles(input int ns);
		return 8'((ns + CLK_NS - 1) / CLK_NS);
	endfunction
	// 20 MHz clock counts to cycles, rounded up
	function automatic logic [7:0] bclk_cycles(input logic [3:0] n);
		logic [15:0] t;
		t = 16'(n) * 16'(BUS_CLK_NS) + 16'(CLK_NS - 1);
		return 8'(t / 16'(CLK_NS));
	endfunction
	localparam logic [7:0] CYC_SETTLE = ns_cycles(SETTLE_NS);
	localparam logic [7:0] CYC_BOOT_SELECT = ns_cycles(BOOT_SELECT_NS);
	localparam logic [7:0] CYC_SETUP = ns_cycles(SETUP_NS);
	localparam logic [7:0] CYC_WRITE_HOLD = ns_cycles(WRITE_HOLD_NS);
	localparam logic [7:0] CYC_RELEASE = ns_cycles(RELEASE_NS);
	localparam logic [7:0] CYC_RECOV_FAST = ns_cycles(RECOV_FAST_NS);
	localparam logic [7:0] CYC_RECOV_SLOW = ns_cycles(RECOV_SLOW_NS);
	// isa i/o offsets inside the 32-byte window
	localparam logic [4:0] IO_CONTROLLER_DATA_PORT = 5'h10;
	localparam logic [4:0] IO_REGISTER_INDEX_PORT = 5'h12;
	localparam logic [4:0] IO_RESET_PORT = 5'h14;
	localparam logic [4:0] IO_CONFIG_DATA_PORT = 5'h16;
	// register bus map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_MADDR = 8'h04;
	localparam logic [7:0] A_MDATA = 8'h08;
	localparam logic [7:0] A_MCMD = 8'h0C;
	localparam int CTRL_BUS_MASTER_BIT = 0;
	localparam int CTRL_RECOV_FAST_BIT = 4;
	localparam int CTRL_READ_ACTIVE_LSB = 8;
	localparam int CTRL_WRITE_ACTIVE_LSB = 12;
	localparam logic [31:0] CTRL_RST = 32'h0000_5510;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [14:0] {
		S_IDLE = 15'h0001, S_PROM_ARB = 15'h0002, S_PROM_DRV = 15'h0004,
		S_REG = 15'h0008, S_WAIT_END = 15'h0010, S_BOOT_ARB = 15'h0020,
		S_BOOT_SEL = 15'h0040, S_BOOT_DRV = 15'h0080, S_M_REQ = 15'h0100,
		S_M_SETTLE = 15'h0200, S_M_SETUP = 15'h0400, S_M_STROBE = 15'h0800,
		S_M_HOLD = 15'h1000, S_M_RECOV = 15'h2000, S_M_REL = 15'h4000
	} isabcu_state_type;
	localparam logic [14:0] MASTER_STATES = 15'h7F00;
	typedef struct packed {
		logic [7:0] awaddr; logic awvalid; logic [31:0] wdata; logic [3:0] wstrb;
		logic wvalid; logic bready; logic [7:0] araddr; logic arvalid; logic rready;
	} isabcu_axil_req_type;
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} isabcu_axil_rsp_type;
	typedef struct packed {
		logic aen; logic [23:0] sa; logic ior_n; logic iow_n; logic smemr_n;
		logic ref_n; logic dack_n; logic iochrdy; logic iocs16_n; logic [15:0] sd;
	} isabcu_isa_in_type;
	typedef struct packed {
		logic [15:0] sd; logic sd_oe_lo; logic sd_oe_hi; logic iochrdy_oe;
		logic iocs16_oe; logic drq; logic master_n; logic [23:0] sa; logic sa_oe;
		logic sbhe_n; logic memr_n; logic memw_n; logic cmd_oe;
	} isabcu_isa_out_type;
	typedef struct packed {
		logic private_data_bus_req; logic [13:0] addr;
		logic station_prom_select_n; logic boot_rom_select_n;
	} isabcu_priv_out_type;
	typedef struct packed {
		logic wr; logic rd; logic bus_config_sel; logic [15:0] idx;
		logic [15:0] wdata; logic reset;
	} isabcu_core_out_type;
	typedef struct packed {
		isabcu_state_type st; isabcu_isa_out_type isa; isabcu_priv_out_type prv;
		isabcu_core_out_type core; logic io16_seen; logic [7:0] hold_byte;
		logic [15:0] register_index_port; logic ack; logic rd_wait;
		logic [31:0] ctrl; logic [23:0] maddr; logic [15:0] mwdata;
		logic [15:0] mrdata; logic mwrite; logic pend;
	} isabcu_main_type;
	localparam isabcu_isa_out_type ISA_OUT_RST = '{master_n: 1'b1, sbhe_n: 1'b1,
		memr_n: 1'b1, memw_n: 1'b1, default: '0};
	localparam isabcu_main_type MAIN_RST = '{st: S_IDLE, isa: ISA_OUT_RST,
		prv: '{station_prom_select_n: 1'b1, boot_rom_select_n: 1'b1, default: '0},
		core: '0, ctrl: CTRL_RST, default: '0};
	localparam isabcu_main_type MAIN_SOFT_RST = '{st: S_WAIT_END, isa: ISA_OUT_RST,
		prv: '{station_prom_select_n: 1'b1, boot_rom_select_n: 1'b1, default: '0},
		core: '{reset: 1'b1, default: '0}, ctrl: CTRL_RST, default: '0};
	// byte-lane merge of a bus write
	function automatic logic [31:0] apply_strb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				v[i*8 +: 8] = nw[i*8 +: 8];
		return v;
	endfunction
	function automatic logic reg_mapped(input logic [7:0] a);
		return a == A_CTRL || a == A_MADDR || a == A_MDATA || a == A_MCMD;
	endfunction
endpackage

// ===== rtl/isabcu_timer.sv
// loadable down counter for strobe widths and waits
`timescale 1ns/10ps
`default_nettype none
module isabcu_timer
#(
	parameter int W = 8 // counter width
)
(
	input wire logic clk, // system clock
	input wire logic nrst, // synchronous reset, active low
	input wire logic load, // take a new count
	input wire logic [W-1:0] count, // cycles until done
	output logic done // count down to one or zero
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} isabcu_timer_type;
	isabcu_timer_type r_ff, nxt_r;
	// load wins over the running count
	always_comb
	begin
		nxt_r = r_ff;
		if (load)
			nxt_r.cnt = count;
		else if (r_ff.cnt != '0)
			nxt_r.cnt = r_ff.cnt - 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (!nrst)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end
	// done at a count of one, so a phase loaded with n lasts n cycles
	assign done = r_ff.cnt[W-1:1] == '0;
endmodule
`default_nettype wire

// ===== rtl/isabcu_axil_slave.sv
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/10ps
`default_nettype none
module isabcu_axil_slave
	import isabcu_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic nrst, // synchronous reset, active low
	input wire isabcu_axil_req_type req, // bus requests
	output var isabcu_axil_rsp_type rsp, // bus answers, registered
	output logic wr_stb, // one-cycle register write
	output logic [7:0] wr_addr, // write byte address
	output logic [31:0] wr_data, // write data
	output logic [3:0] wr_strb, // write byte enables
	input wire logic wr_ok, // write address is mapped
	output logic [7:0] rd_addr, // read byte address
	input wire logic [31:0] rd_data, // read word for rd_addr
	input wire logic rd_ok // read address is mapped
);
	typedef struct packed {
		isabcu_axil_rsp_type rsp; logic aw_have; logic w_have; logic [7:0] awaddr;
		logic [31:0] wdata; logic [3:0] wstrb; logic wr_stb;
	} isabcu_slave_type;
	isabcu_slave_type r_ff, nxt_r;
	// address and data are taken in either order, answer follows both
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.wr_stb = 1'b0;
		if (req.awvalid && r_ff.rsp.awready)
		begin
			nxt_r.aw_have = 1'b1;
			nxt_r.awaddr = req.awaddr;
		end
		if (req.wvalid && r_ff.rsp.wready)
		begin
			nxt_r.w_have = 1'b1;
			nxt_r.wdata = req.wdata;
			nxt_r.wstrb = req.wstrb;
		end
		if (r_ff.aw_have && r_ff.w_have && !r_ff.rsp.bvalid)
		begin
			nxt_r.wr_stb = wr_ok;
			nxt_r.rsp.bvalid = 1'b1;
			nxt_r.rsp.bresp = wr_ok ? RESP_OKAY : RESP_DECERR;
			nxt_r.aw_have = 1'b0;
			nxt_r.w_have = 1'b0;
		end
		if (r_ff.rsp.bvalid && req.bready)
			nxt_r.rsp.bvalid = 1'b0;
		// ready stays low while a write is held, so the held address stays put
		nxt_r.rsp.awready = !nxt_r.aw_have && !nxt_r.rsp.bvalid;
		nxt_r.rsp.wready = !nxt_r.w_have && !nxt_r.rsp.bvalid;
		if (req.arvalid && r_ff.rsp.arready)
		begin
			nxt_r.rsp.arready = 1'b0;
			nxt_r.rsp.rvalid = 1'b1;
			nxt_r.rsp.rdata = rd_ok ? rd_data : 32'h0000_0000;
			nxt_r.rsp.rresp = rd_ok ? RESP_OKAY : RESP_DECERR;
		end
		if (r_ff.rsp.rvalid && req.rready)
		begin
			nxt_r.rsp.rvalid = 1'b0;
			nxt_r.rsp.arready = 1'b1;
		end
	end
	always_ff @(posedge clk)
	begin
		if (!nrst)
			r_ff <= '{rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
				default: '0};
		else
			r_ff <= nxt_r;
	end
	assign rsp = r_ff.rsp;
	assign wr_stb = r_ff.wr_stb;
	assign wr_addr = r_ff.awaddr;
	assign wr_data = r_ff.wdata;
	assign wr_strb = r_ff.wstrb;
	assign rd_addr = req.araddr;
endmodule
`default_nettype wire

// ===== sim/isabcu_props.sv
// pin-level assertions for the isa bus cycle unit
`timescale 1ns/10ps
`default_nettype none
module isabcu_props
	import isabcu_pkg::*;
(
	input wire logic clk, // clock
	input wire logic nrst, // sync reset
	input wire isabcu_isa_in_type isa_i, // pin levels
	input wire isabcu_isa_out_type isa_o, // pin drives
	input wire isabcu_priv_out_type prv_o, // private bus
	input wire isabcu_core_out_type core_o // core access
);
	logic [7:0] bsel_ff;
	logic [7:0] mst_ff;
	// cycles with select low and with bus held; the bus count saturates so long holds stay legal
	always_ff @(posedge clk)
	begin
		bsel_ff <= prv_o.boot_rom_select_n ? 8'h00 : bsel_ff + 8'h01;
		mst_ff <= isa_o.master_n ? 8'h00 : mst_ff + {7'h00, mst_ff != 8'hFF};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence prom_on;
		$fell(prv_o.station_prom_select_n);
	endsequence
	sequence rel_on;
		$fell(isa_o.drq);
	endsequence
	a_prom_narrow: assert property (!prv_o.station_prom_select_n |-> !isa_o.iocs16_oe && !isa_o.sd_oe_hi) else $error("prom wide");
	a_prom_drive: assert property (prom_on |=> isa_o.sd_oe_lo && !isa_o.iochrdy_oe) else $error("prom drive");
	a_boot_width: assert property ($rose(prv_o.boot_rom_select_n) |-> bsel_ff == 8'h26) else $error("boot width");
	a_bus_settle: assert property ($rose(isa_o.sa_oe) |-> mst_ff >= 8'h26) else $error("settle");
	a_addr_setup: assert property ($fell(isa_o.memr_n) || $fell(isa_o.memw_n) |-> $past(isa_o.sa_oe, 13)) else $error("setup");
	a_write_hold: assert property ($rose(isa_o.memw_n) |-> ##12 isa_o.sd_oe_lo && isa_o.sd == $past(isa_o.sd, 12)) else $error("hold");
	a_release_seq: assert property (rel_on |-> isa_o.memr_n && isa_o.memw_n && !isa_o.sa_oe ##13 $rose(isa_o.master_n)) else $error("release");
	a_master_grant: assert property ($fell(isa_o.master_n) |-> $past(isa_o.drq) && !$past(isa_i.dack_n)) else $error("grant");
	a_reset_narrow: assert property (core_o.reset |-> !isa_o.iocs16_oe) else $error("reset wide");
endmodule
bind isabcu_top isabcu_props isabcu_props_i (.clk(clk), .nrst(nrst), .isa_i(isa_i), .isa_o(isa_o), .prv_o(prv_o), .core_o(core_o));
`default_nettype wire

// ===== sim/isabcu_pm.sv
// permanent bus master: grants the bus on request
`timescale 1ns/10ps
`default_nettype none
module isabcu_pm
(
	input wire logic clk, // clock
	input wire logic drq, // bus request
	input wire logic master_n, // device holds bus
	output logic dack_n, // acknowledge, active low
	output logic aen // dma address enable
);
	logic [7:0] hold_ff = 8'h00;
	initial dack_n = 1'b1;
	initial aen = 1'b0;
	// ack kept 94 cycles past request drop; aen off while device holds bus
	always @(posedge clk)
	begin
		hold_ff <= drq ? 8'h00 : hold_ff + {7'h00, hold_ff != 8'hFF};
		if (drq)
			dack_n <= 1'b0;
		else if (hold_ff >= 8'h5E)
			dack_n <= 1'b1;
		aen <= !dack_n && master_n;
	end
endmodule
`default_nettype wire

// ===== sim/isabcu_bench.sv
// self-checking bench of the isa bus cycle unit
`timescale 1ns/10ps
`default_nettype none
module isabcu_bench
	import isabcu_pkg::*;
;
	localparam logic [15:0] IOB = 16'h0300;
	localparam logic [23:0] BOOTB = 24'h0C8000;
	logic clk = 0, nrst = 0, gnt = 0;
	isabcu_axil_req_type ai = '0;
	isabcu_axil_rsp_type ao;
	isabcu_isa_in_type ii = '{ior_n:1, iow_n:1, smemr_n:1, ref_n:1, dack_n:1, iochrdy:1, default:0};
	isabcu_isa_in_type ic;
	isabcu_isa_out_type so;
	isabcu_priv_out_type po;
	isabcu_core_out_type co;
	logic [7:0] pd = 0, q8;
	logic [15:0] cr = 0, wd, sd_c, d16;
	logic [23:0] sa_c, a24;
	logic [31:0] q;
	logic [1:0] r;
	logic [3:0] w;
	wire dk, ae;
	int n_mismatch = 0, check_count = 0, cyc = 0, nw = 0, nr = 0, sw = 0, k, n;
	always #2 clk = ~clk;
	always_comb
	begin
		ic = ii;
		ic.dack_n = dk;
		ic.aen = ae;
	end
	isabcu_top #(.IO_BASE(IOB), .BOOT_BASE(BOOTB)) isabcu_top_i (.clk(clk), .nrst(nrst),
		.axi_i(ai), .axi_o(ao), .isa_i(ic), .isa_o(so), .private_data_bus_gnt(gnt),
		.private_data_lines(pd), .prv_o(po), .core_o(co), .core_rdata(cr));
	isabcu_pm isabcu_pm_i (.clk(clk), .drq(so.drq), .master_n(so.master_n), .dack_n(dk), .aen(ae));
	// grant follows request; watch core pulses, strobes and the hang limit
	always @(posedge clk)
	begin
		gnt <= po.private_data_bus_req;
		cyc++;
		if (co.wr)
		begin
			nw++;
			wd = co.wdata;
		end
		nr += co.reset;
		if (!so.memr_n || !so.memw_n)
		begin
			sw++;
			sa_c = so.sa;
			sd_c = so.sd;
		end
		if (cyc == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end
	task chk(input string s, input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ai <= '{awaddr:a, awvalid:1, wdata:d, wstrb:4'hF, wvalid:1, bready:1, default:0};
		do
		begin
			@(posedge clk);
			if (ao.awready && ai.awvalid)
				ai.awvalid <= 0;
			if (ao.wready && ai.wvalid)
				ai.wvalid <= 0;
		end
		while (!ao.bvalid);
		ai.bready <= 0;
	endtask
	task axr(input logic [7:0] a);
		@(posedge clk);
		ai <= '{araddr:a, arvalid:1, rready:1, default:0};
		do
		begin
			@(posedge clk);
			if (ao.arready)
				ai.arvalid <= 0;
		end
		while (!ao.rvalid);
		q = ao.rdata;
		r = ao.rresp;
		ai.rready <= 0;
	endtask
	// one slave cycle, held until ready comes back; low lane only in byte mode
	task io(input logic [4:0] off, input logic wr, input logic [7:0] d);
		@(posedge clk);
		ii.sa <= {8'h00, IOB | {11'h000, off}};
		ii.sd <= {~d, d};
		ii.ior_n <= wr;
		ii.iow_n <= !wr;
		repeat (3) @(posedge clk);
		while (so.iochrdy_oe)
			@(posedge clk);
		q8 = so.sd[7:0];
		chk("wide", {so.sd_oe_hi, so.iocs16_oe}, 0);
		ii.ior_n <= 1;
		ii.iow_n <= 1;
		repeat (2) @(posedge clk);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(81));
		repeat (16) @(posedge clk);
		nrst <= 1;
		axr(A_CTRL);
		chk("ctrl", q, CTRL_RST);
		axr(8'h40);
		chk("decerr", r, RESP_DECERR);
		// byte-wide pair of writes, then even and odd byte reads
		d16 = $urandom;
		k = nw;
		io(5'h10, 1, d16[7:0]);
		io(5'h11, 1, d16[15:8]);
		chk("wr count", nw - k, 1);
		chk("merge", wd, d16);
		cr <= $urandom;
		io(5'h10, 0, 0);
		chk("even rd", q8, cr[7:0]);
		io(5'h11, 0, 0);
		chk("odd rd", q8, cr[15:8]);
		$display("test regs done");
		for (n = 0; n < 3; n++)
		begin
			pd <= $urandom;
			io(5'($urandom_range(0, 15)), 0, 0);
			chk("prom", q8, pd);
		end
		axw(A_CTRL, 32'h0000_1234);
		k = nr;
		io(5'h14, 0, 0);
		chk("reset", nr - k, 1);
		axr(A_CTRL);
		chk("ctrl back", q, CTRL_RST);
		$display("test prom reset done");
		// master write then read, random strobe width
		for (n = 0; n < 2; n++)
		begin
			w = $urandom_range(1, 15);
			a24 = $urandom;
			d16 = $urandom;
			ii.sd <= d16;
			axw(A_CTRL, {16'h0000, w, w, 8'h11});
			axw(A_MADDR, {8'h00, a24});
			axw(A_MDATA, {16'h0000, d16});
			sw = 0;
			axw(A_MCMD, (n == 0) ? 32'h1 : 32'h0);
			while (so.master_n)
				@(posedge clk);
			while (!so.master_n)
				@(posedge clk);
			chk("strobe", sw, (w * 50 + 3) / 4);
			chk("addr", sa_c, a24);
			if (n == 0)
				chk("wdata", sd_c, d16);
			axr(A_MCMD);
			chk("rdata", q[31:16], (n == 0) ? 16'h0000 : d16);
		end
		$display("test master done");
		while (!dk)
			@(posedge clk);
		repeat (16) @(posedge clk);
		pd <= $urandom;
		ii.sa <= {BOOTB[23:14], 14'h0055};
		ii.ref_n <= 0;
		ii.smemr_n <= 0;
		repeat (4) @(posedge clk);
		chk("refresh", so.iochrdy_oe, 0);
		ii.ref_n <= 1;
		ii.smemr_n <= 1;
		@(posedge clk);
		ii.smemr_n <= 0;
		repeat (3) @(posedge clk);
		while (so.iochrdy_oe)
			@(posedge clk);
		chk("boot", {so.sd_oe_hi, so.sd[7:0]}, {1'b0, pd});
		ii.smemr_n <= 1;
		repeat (4) @(posedge clk);
		$display("test boot done");
		wrap_up();
	end
endmodule
`default_nettype wire
